// [core/pgtm_defines.vh]
// register map and field layout of the power-good tree mask block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef PGTM_DEFINES_VH
`define PGTM_DEFINES_VH

// printed offsets a6, a7 and a9 are not multiples of four: all four are word indices
`define PGTM_IDX_D_REG      10'h0a6
`define PGTM_IDX_D_PIN      10'h0a7
`define PGTM_IDX_B_REG      10'h0a8
`define PGTM_IDX_B_PIN      10'h0a9
`define PGTM_ADDR_W         10
`define PGTM_ADDR_HI        11
`define PGTM_ADDR_LO        2
`define PGTM_MASK_HI        7
`define PGTM_PIN_LO         8
`define PGTM_RDATA_RST      32'h00000000
`define PGTM_SYNC_RST       8'h00
`define PGTM_RST_D_REG      8'h00
`define PGTM_RST_D_PIN      8'h00
`define PGTM_RST_B_REG      8'hc0
`define PGTM_RST_B_PIN      8'h2f
`define PGTM_SRC_W          16
// second mask register fields
`define PGTM_BIT_TERM       3
`define PGTM_CTL_HI         7
`define PGTM_CTL_LO         4
`define PGTM_CTL_W          4
`define PGTM_ZERO_HI        24'h000000

`endif

// [core/pgtm_power_good_tree_mask.v]
// power-good tree masks for general output pins d and b, apb slave
// assumes regulator good inputs are levels from other clock domains
// and control pins arrive asynchronously; all are double-synchronised
// apb master is on pclk; pready stands high, so every access is one
// cycle long and read data is loaded at the setup edge
//
// Behaviour
// (RULE1) mask bit 0 includes source, 1 ignores it
// (RULE2) pin d regulator mask at a6, reset 00
// (RULE3) pin d control/switch mask at a7, reset 00
// (RULE4) control pin level feeds pin d tree
// (RULE5) termination regulator good feeds pin d tree
// (RULE6) pin b regulator mask at a8, reset c0
// (RULE7) all masks read back last written value
// (RULE8) pin b second mask at a9, reset 2f
// (RULE9) output good only when every included source good
`timescale 1ns/1ps
`include "pgtm_defines.vh"

module pgtm_power_good_tree_mask (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // regulator group, bit order as first mask register
  input  wire [7:0]  reg_group_good,
  // bit order as second mask register: ctl5 ctl4 ctl2 ctl1 term swb2
  // swb1 ldo_a3
  input  wire [7:0]  pin_group_good,
  output reg         general_output_pin_d,
  output reg         general_output_pin_b
);

  // mask registers, one per mapped word
  reg  [7:0]              d_reg_r;
  reg  [7:0]              d_pin_r;
  reg  [7:0]              b_reg_r;
  reg  [7:0]              b_pin_r;

  // synchroniser stages per source group
  reg  [7:0]              reg_sync1_r;
  reg  [7:0]              reg_sync2_r;
  reg  [7:0]              pin_sync1_r;
  reg  [7:0]              pin_sync2_r;

  // bus decode and read path
  reg  [31:0]             rdata_nxt;
  reg                     hit_nxt;
  wire [`PGTM_ADDR_W-1:0] word_idx;
  wire                    access;
  wire                    setup_rd;
  wire                    wr_en;
  wire                    sel_d_reg;
  wire                    sel_d_pin;
  wire                    sel_b_reg;
  wire                    sel_b_pin;

  // tree terms
  wire [`PGTM_SRC_W-1:0]  src_good;
  wire [`PGTM_SRC_W-1:0]  d_ignore;
  wire [`PGTM_SRC_W-1:0]  b_ignore;
  wire [`PGTM_SRC_W-1:0]  d_ok;
  wire [`PGTM_SRC_W-1:0]  b_ok;
  wire                    d_reg_all;
  wire                    d_pin_all;
  wire                    b_reg_all;
  wire                    b_pin_all;

  assign word_idx = paddr[`PGTM_ADDR_HI:`PGTM_ADDR_LO];
  assign access   = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_en    = access & pwrite & hit_nxt;

  // decode of the four mapped word indices
  assign sel_d_reg = (word_idx == `PGTM_IDX_D_REG);
  assign sel_d_pin = (word_idx == `PGTM_IDX_D_PIN);
  assign sel_b_reg = (word_idx == `PGTM_IDX_B_REG);
  assign sel_b_pin = (word_idx == `PGTM_IDX_B_PIN);

  // zero wait state slave: pready stands high from reset on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  // no error response, unmapped words read as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always @* begin
    hit_nxt   = 1'b0;
    rdata_nxt = `PGTM_RDATA_RST;
    if (sel_d_reg) begin
      hit_nxt   = 1'b1;
      rdata_nxt = {`PGTM_ZERO_HI, d_reg_r};
    end else if (sel_d_pin) begin
      hit_nxt   = 1'b1;
      rdata_nxt = {`PGTM_ZERO_HI, d_pin_r};
    end else if (sel_b_reg) begin
      hit_nxt   = 1'b1;
      rdata_nxt = {`PGTM_ZERO_HI, b_reg_r};
    end else if (sel_b_pin) begin
      hit_nxt   = 1'b1;
      rdata_nxt = {`PGTM_ZERO_HI, b_pin_r};
    end
  end

  // read data registered in setup so it is stable during access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PGTM_RDATA_RST;
    end else if (setup_rd) begin
      prdata <= rdata_nxt; // [RULE7]
    end
  end

  // pin d regulator group mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_reg_r <= `PGTM_RST_D_REG; // [RULE2]
    end else if (wr_en & sel_d_reg) begin
      d_reg_r <= pwdata[`PGTM_MASK_HI:0]; // [RULE7]
    end
  end

  // pin d control pin, termination and switch mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_pin_r <= `PGTM_RST_D_PIN; // [RULE3]
    end else if (wr_en & sel_d_pin) begin
      d_pin_r <= pwdata[`PGTM_MASK_HI:0]; // [RULE7]
    end
  end

  // pin b regulator group mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_reg_r <= `PGTM_RST_B_REG; // [RULE6]
    end else if (wr_en & sel_b_reg) begin
      b_reg_r <= pwdata[`PGTM_MASK_HI:0]; // [RULE7]
    end
  end

  // pin b control pin, termination and switch mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_pin_r <= `PGTM_RST_B_PIN; // [RULE8]
    end else if (wr_en & sel_b_pin) begin
      b_pin_r <= pwdata[`PGTM_MASK_HI:0]; // [RULE7]
    end
  end

  // two-flop synchronisers: regulator good levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_sync1_r <= `PGTM_SYNC_RST;
      reg_sync2_r <= `PGTM_SYNC_RST;
    end else begin
      reg_sync1_r <= reg_group_good;
      reg_sync2_r <= reg_sync1_r;
    end
  end

  // control pin levels and termination good, same two stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_r <= `PGTM_SYNC_RST;
      pin_sync2_r <= `PGTM_SYNC_RST;
    end else begin
      pin_sync1_r <= pin_group_good;
      pin_sync2_r <= pin_sync1_r; // [RULE4] [RULE5]
    end
  end

  assign src_good = {pin_sync2_r, reg_sync2_r};
  assign d_ignore = {d_pin_r, d_reg_r};
  assign b_ignore = {b_pin_r, b_reg_r};

  genvar i;
  generate
    for (i = 0; i < `PGTM_SRC_W; i = i + 1) begin : g_src
      assign d_ok[i] = d_ignore[i] | src_good[i]; // [RULE1]
      assign b_ok[i] = b_ignore[i] | src_good[i]; // [RULE1]
    end
  endgenerate

  // per group and over included sources
  assign d_reg_all = &d_ok[`PGTM_MASK_HI:0];
  assign d_pin_all = &d_ok[`PGTM_SRC_W-1:`PGTM_PIN_LO];
  assign b_reg_all = &b_ok[`PGTM_MASK_HI:0];
  assign b_pin_all = &b_ok[`PGTM_SRC_W-1:`PGTM_PIN_LO];

  // pin d power good
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output_pin_d <= 1'b0;
    end else begin
      general_output_pin_d <= d_reg_all & d_pin_all; // [RULE9]
    end
  end

  // pin b power good
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output_pin_b <= 1'b0;
    end else begin
      general_output_pin_b <= b_reg_all & b_pin_all; // [RULE9]
    end
  end

endmodule // pgtm_power_good_tree_mask

// [test/pgtm_props.sv]
// port assertions for the tree mask block
// bound into every instance of the block
`timescale 1ns/1ps
module pgtm_props (input wire pclk, presetn, psel, penable, pwrite,
  pready, pslverr, general_output_pin_d, general_output_pin_b,
  input wire [11:0] paddr, input wire [31:0] prdata,
  input wire [7:0] reg_group_good, pin_group_good);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ok = &reg_group_good && &pin_group_good;
  wire nm = paddr[11:2] < 10'h0a6 || paddr[11:2] > 10'h0a9;
  a_ready_high: assert property (pready) else $error("rdy");
  a_no_slverr: assert property (!pslverr) else $error("err");
  a_upper_zero: assert property (prdata[31:8] == 0) else $error("hi");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && nm
    |=> prdata == 0) else $error("unmapped");
  a_good_pin_d: assert property (ok [*4] |=> general_output_pin_d)
    else $error("d");
  a_good_pin_b: assert property (ok [*4] |=> general_output_pin_b)
    else $error("b");
  a_reset_pin_d: assert property ($rose(presetn) |-> !general_output_pin_d)
    else $error("d rst");
  a_reset_pin_b: assert property ($rose(presetn) |-> !general_output_pin_b)
    else $error("b rst");
  c_pin_d: cover property (general_output_pin_d);
  c_pin_b: cover property (general_output_pin_b);
  c_write: cover property (psel && penable && pwrite);
endmodule // pgtm_props
bind pgtm_power_good_tree_mask pgtm_props u_pgtm_props (.*);

// [test/pgtm_src_model.sv]
// source model: regulator good and control pin levels
// levels follow lvl one pclk edge later
`timescale 1ns/1ps
module pgtm_src_model (input wire pclk, input wire [15:0] lvl,
  output reg [7:0] reg_group_good, pin_group_good);
  always @(posedge pclk) {pin_group_good, reg_group_good} <= lvl;
endmodule // pgtm_src_model

// [test/test_pgtm_power_good_tree_mask.sv]
// bench for the tree mask block over apb
// assumes zero-wait slave and three-edge source latency
`timescale 1ns/1ps
module test_pgtm_power_good_tree_mask;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, q;
  reg [15:0] lvl = 16'hffff;
  wire [31:0] prdata;
  wire pready, pslverr, general_output_pin_d, general_output_pin_b;
  wire [7:0] reg_group_good, pin_group_good;
  integer errors = 0, checked = 0, i, j;
  initial forever #12.5 pclk = ~pclk;
  pgtm_src_model u_pgtm_src_model (.*);
  pgtm_power_good_tree_mask u_pgtm_power_good_tree_mask (.*);
  task chk(input [31:0] s, input [31:0] e); begin
    checked = checked + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task xfer(input w, input [7:0] x, input [31:0] d); begin
    psel <= 1; pwrite <= w; paddr <= {2'h0, x, 2'h0}; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk) while (!pready) @(posedge pclk);
    q = prdata; psel <= 0; penable <= 0; @(posedge pclk);
  end endtask
  task pins(input [15:0] m, input [15:0] l, input e); begin
    xfer(1, 8'ha6, m[7:0]); xfer(1, 8'ha7, m[15:8]);
    xfer(1, 8'ha8, m[7:0]); xfer(1, 8'ha9, m[15:8]);
    lvl <= l; repeat (6) @(posedge pclk);
    chk({general_output_pin_d, general_output_pin_b}, {e, e});
  end endtask
  task t_regs; begin
    for (i = 0; i < 5; i = i + 1) begin
      xfer(0, 8'ha6 + i, 0);
      chk(q, 40'h0000c02f00 >> (32 - 8 * i) & 8'hff);
      xfer(1, 8'ha6 + i, 8'h5a + i); xfer(0, 8'ha6 + i, 0);
      chk(q, i < 4 ? 8'h5a + i : 0);
    end
  end endtask
  task t_tree; begin
    pins(0, 16'hffff, 1);
    for (i = 0; i < 16; i = i + 1) begin
      pins(0, ~(16'h1 << i), 0);
      pins(16'hffff, ~(16'h1 << i), 1);
      pins(16'h1 << i, ~(16'h1 << i), 1);
    end
  end endtask
  task final_report; begin
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  end endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1; @(posedge pclk);
    t_regs; t_tree; final_report;
  end
  // about 1000 cycles expected, cut at 20000
  initial begin #500000; errors = errors + 1; final_report; end
endmodule // test_pgtm_power_good_tree_mask
